// file: ars_pkg.sv
// Purpose: Constants and types for the accelerometer output register bank
// Assumes: 20 MHz pclk, APB word per register, byte address = 4 * index
// Notes:   Identity code value is arbitrary
// Notes on behaviour
// - Read-only identity byte at index zero.
// - Fault code in bits 4:2; 1 means bad sampling configuration.
// - Fatal bit 0 set on boot/power failure; cleared by reset or the soft reset command.
// - Data-ready status bit 7 set on new sample, cleared by axis read.
// - Each axis is signed 16 bits: high byte * 256 + low byte.
// - Low byte read freezes matching high byte until it is read.
// - 24-bit time counter in three bytes, low byte steps every 39.0625 us.
// - Middle and high bytes carry on overflow; wraps after 655.36 s.
// - Interrupt status bit 7 flags data ready, cleared by reading it.
// - Temperature 11-bit signed, high byte bits 10:3, low byte top three.
// - Temperature refreshed every 1.28 s.
// - Buffer fill level in bytes, 14 bits over two count registers.
// - Empty buffer reads 0x8000 from the count pair.
// - Buffer cleared when all frames read or 0xb0 written to command.
// - Byte count changes only on whole frames written or read.
// - Repeated port reads return successive bytes, address never moves.
// - Partly read frame is delivered again from its first byte.
// - Overflow after a partial read may drop that frame.
package ars_pkg;
    localparam int unsigned ADDR_W = 10;
    // Register indexes
    localparam logic [7:0] IDX_IDENTITY = 8'h00;
    localparam logic [7:0] IDX_FAULT    = 8'h02;
    localparam logic [7:0] IDX_STATUS   = 8'h03;
    localparam logic [7:0] IDX_AXIS_LO  = 8'h12;
    localparam logic [7:0] IDX_AXIS_HI  = 8'h17;
    localparam logic [7:0] IDX_TIME_0   = 8'h18;
    localparam logic [7:0] IDX_TIME_1   = 8'h19;
    localparam logic [7:0] IDX_TIME_2   = 8'h1a;
    localparam logic [7:0] IDX_IRQ      = 8'h1d;
    localparam logic [7:0] IDX_TEMP_HI  = 8'h22;
    localparam logic [7:0] IDX_TEMP_LO  = 8'h23;
    localparam logic [7:0] IDX_CNT_LO   = 8'h24;
    localparam logic [7:0] IDX_CNT_HI   = 8'h25;
    localparam logic [7:0] IDX_PORT     = 8'h26;
    localparam logic [7:0] IDX_CMD      = 8'h7e;
    // Fields and values
    localparam logic [7:0] IDENTITY_CODE = 8'h5c; // Arbitrary value
    localparam int unsigned DRDY_BIT     = 7;
    localparam int unsigned FATAL_BIT    = 0;
    localparam int unsigned ERR_LSB      = 2;
    localparam logic [2:0] ERR_NONE      = 3'h0;
    localparam logic [2:0] ERR_CFG       = 3'h1;
    localparam logic [7:0] CMD_FLUSH     = 8'hb0;
    localparam logic [7:0] CMD_SOFT_RST  = 8'ha5;
    localparam logic [7:0] EMPTY_CNT_HI  = 8'h80;
    localparam logic [7:0] EMPTY_PORT    = 8'h00;
    // Timing
    localparam int unsigned CLK_PERIOD_PS  = 50000;
    localparam int unsigned CLK_PERIOD_NS  = CLK_PERIOD_PS / 1000;
    localparam int unsigned TICK_PERIOD_PS = 39062500; // 39.0625 us
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_PS / CLK_PERIOD_PS;
    localparam int unsigned TEMP_PERIOD_NS = 1280000000; // 1.28 s
    localparam int unsigned TEMP_CYCLES    = TEMP_PERIOD_NS / CLK_PERIOD_NS;
    // Sample buffer
    localparam int unsigned FRAME_BYTES = 6;
    localparam int unsigned BUF_BYTES   = 1024;
    localparam int unsigned BUF_FRAMES  = BUF_BYTES / FRAME_BYTES;
    localparam int unsigned FRAME_W     = 8 * FRAME_BYTES;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } ars_apb_e;
endpackage

// file: ars_buf_if.sv
// Purpose: Carrier between register bank and frame memory
// Assumes: Single clock, one frame per word
// Notes:   Read data registered inside the memory
`timescale 1ns/1ps
interface ars_buf_if;
    logic                       wr_en;
    logic [7:0]                 wr_addr;
    logic [ars_pkg::FRAME_W-1:0] wr_data;
    logic [7:0]                 rd_addr;
    logic [ars_pkg::FRAME_W-1:0] rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// file: ars_frame_mem.sv
// Purpose: Frame store of the sample buffer
// Assumes: Addresses below the frame depth
// Notes:   One cycle read latency, same-slot writes forwarded
`timescale 1ns/1ps
module ars_frame_mem (
    // Clock
    input wire logic clk,
    // Memory side
    ars_buf_if.mem   bus
);
    logic [ars_pkg::FRAME_W-1:0] store [ars_pkg::BUF_FRAMES];

    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            store[bus.wr_addr] <= bus.wr_data;
        end
        // Else a frame landing in the read slot shows stale data
        if (bus.wr_en && bus.wr_addr == bus.rd_addr) begin
            bus.rd_data <= bus.wr_data;
        end else begin
            bus.rd_data <= store[bus.rd_addr];
        end
    end
endmodule

// file: ars_output_regs.sv
// Purpose: APB register bank for accelerometer output, status and buffer
// Assumes: Sample and temperature inputs synchronous to pclk
// Notes:   Answers each transfer after one wait cycle
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module ars_output_regs #(
    parameter int unsigned TEMP_CYCLES = ars_pkg::TEMP_CYCLES
) (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ars_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Sensor core
    input  wire logic                       sample_valid,
    input  wire logic [15:0]                sample_x,
    input  wire logic [15:0]                sample_y,
    input  wire logic [15:0]                sample_z,
    input  wire logic [10:0]                temp_value,
    input  wire logic                       fatal_fault,
    input  wire logic                       config_invalid
);
    localparam logic [9:0] TICK_LAST =
        10'(ars_pkg::TICK_CYCLES - 1);
    localparam logic [24:0] TEMP_LAST = 25'(TEMP_CYCLES - 1);
    localparam logic [7:0] FRAMES = 8'(ars_pkg::BUF_FRAMES);
    localparam logic [2:0] LAST_BYTE = 3'(ars_pkg::FRAME_BYTES - 1);

    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == ars_pkg::IDX_IDENTITY) ||
                    (i == ars_pkg::IDX_FAULT) ||
                    (i == ars_pkg::IDX_STATUS) ||
                    is_axis(i) ||
                    (i >= ars_pkg::IDX_TIME_0 && i <= ars_pkg::IDX_TIME_2) ||
                    (i == ars_pkg::IDX_IRQ) ||
                    (i >= ars_pkg::IDX_TEMP_HI && i <= ars_pkg::IDX_PORT) ||
                    (i == ars_pkg::IDX_CMD);
    endfunction

    function automatic logic is_axis(input logic [7:0] i);
        is_axis = (i >= ars_pkg::IDX_AXIS_LO) && (i <= ars_pkg::IDX_AXIS_HI);
    endfunction

    // Axis number 0..2 of an axis register index
    function automatic logic [1:0] axis_of(input logic [7:0] i);
        logic [7:0] d;
        d = i - ars_pkg::IDX_AXIS_LO;
        axis_of = d[2:1];
    endfunction

    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        next_ptr = (p == FRAMES - 8'h01) ? 8'h00 : p + 8'h01;
    endfunction

    ars_buf_if buf_bus ();

    ars_frame_mem u_mem (
        .clk (pclk),
        .bus (buf_bus)
    );

    // Transfer decode
    ars_pkg::ars_apb_e state_reg, state_next;
    logic [7:0]        prdata_reg, prdata_next;
    logic              slverr_reg, slverr_next;
    logic [7:0]        idx;
    logic              hit, acc, rd, wr, cmd_flush, cmd_soft;

    assign idx  = paddr[9:2];
    assign acc  = psel && penable && (state_reg == ars_pkg::ST_IDLE);
    assign hit  = (paddr[1:0] == 2'b00) && is_mapped(idx);
    assign rd   = acc && !pwrite && hit;
    assign wr   = acc && pwrite && hit;
    // Only the command register takes writes
    assign cmd_flush = wr && idx == ars_pkg::IDX_CMD &&
                       pwdata[7:0] == ars_pkg::CMD_FLUSH;
    assign cmd_soft  = wr && idx == ars_pkg::IDX_CMD &&
                       pwdata[7:0] == ars_pkg::CMD_SOFT_RST;

    assign prdata  = {24'h000000, prdata_reg};
    assign pready  = (state_reg == ars_pkg::ST_RESP);
    assign pslverr = pready && slverr_reg;

    // Sensor state
    logic [47:0] samp_reg, samp_next;
    logic [2:0]  lock_reg, lock_next;
    logic [23:0] hold_reg, hold_next;
    logic        drdy_reg, drdy_next;
    logic        irq_reg, irq_next;
    logic        fatal_reg, fatal_next;
    logic [23:0] time_reg, time_next;
    logic [9:0]  tick_reg, tick_next;
    logic [10:0] temp_reg, temp_next;
    logic [24:0] tcnt_reg, tcnt_next;

    // Buffer state
    logic [7:0] wptr_reg, wptr_next;
    logic [7:0] rptr_reg, rptr_next;
    logic [7:0] nfrm_reg, nfrm_next;
    logic [2:0] bidx_reg, bidx_next;
    logic       port_rd, pop_frame, full;
    logic [13:0] byte_cnt;
    logic [7:0]  port_byte;

    assign port_rd   = rd && idx == ars_pkg::IDX_PORT && nfrm_reg != 8'h00;
    assign pop_frame = port_rd && bidx_reg == LAST_BYTE;
    assign full      = nfrm_reg == FRAMES;
    // Whole frames only, so the count never shows a partial frame
    assign byte_cnt  = 14'(nfrm_reg * ars_pkg::FRAME_BYTES);
    assign port_byte = buf_bus.rd_data[bidx_reg*8 +: 8];

    assign buf_bus.wr_en   = sample_valid;
    assign buf_bus.wr_addr = wptr_reg;
    assign buf_bus.wr_data = {sample_z, sample_y, sample_x};
    // One cycle ahead, so the data stand for rptr_reg
    assign buf_bus.rd_addr = rptr_next;

    // Read mux
    always_comb begin
        logic [1:0] ax;
        ax = axis_of(idx);
        prdata_next = prdata_reg;
        slverr_next = slverr_reg;
        if (acc) begin
            slverr_next = !hit;
            prdata_next = 8'h00;
            if (!pwrite && hit) begin
                case (idx)
                    ars_pkg::IDX_IDENTITY: begin
                        prdata_next = ars_pkg::IDENTITY_CODE;
                    end
                    ars_pkg::IDX_FAULT: begin
                        prdata_next[ars_pkg::ERR_LSB +: 3] = config_invalid ?
                            ars_pkg::ERR_CFG : ars_pkg::ERR_NONE;
                        prdata_next[ars_pkg::FATAL_BIT] = fatal_reg;
                    end
                    ars_pkg::IDX_STATUS: begin
                        prdata_next[ars_pkg::DRDY_BIT] = drdy_reg;
                    end
                    ars_pkg::IDX_TIME_0: prdata_next = time_reg[7:0];
                    ars_pkg::IDX_TIME_1: prdata_next = time_reg[15:8];
                    ars_pkg::IDX_TIME_2: prdata_next = time_reg[23:16];
                    ars_pkg::IDX_IRQ: begin
                        prdata_next[ars_pkg::DRDY_BIT] = irq_reg;
                    end
                    ars_pkg::IDX_TEMP_HI: prdata_next = temp_reg[10:3];
                    ars_pkg::IDX_TEMP_LO: begin
                        prdata_next = {temp_reg[2:0], 5'h00};
                    end
                    ars_pkg::IDX_CNT_LO: begin
                        prdata_next = byte_cnt[7:0];
                    end
                    ars_pkg::IDX_CNT_HI: begin
                        prdata_next = (nfrm_reg == 8'h00) ?
                            ars_pkg::EMPTY_CNT_HI :
                            {2'b00, byte_cnt[13:8]};
                    end
                    ars_pkg::IDX_PORT: begin
                        prdata_next = (nfrm_reg == 8'h00) ?
                            ars_pkg::EMPTY_PORT : port_byte;
                    end
                    default: begin
                        if (is_axis(idx) && idx[0]) begin
                            prdata_next = lock_reg[ax] ? hold_reg[ax*8 +: 8] :
                                samp_reg[ax*16+8 +: 8];
                        end else if (is_axis(idx)) begin
                            prdata_next = samp_reg[ax*16 +: 8];
                        end
                    end
                endcase
            end
        end
    end

    always_comb begin
        case (state_reg)
            ars_pkg::ST_IDLE: begin
                state_next = acc ? ars_pkg::ST_RESP : ars_pkg::ST_IDLE;
            end
            ars_pkg::ST_RESP: state_next = ars_pkg::ST_IDLE;
            default:          state_next = ars_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ars_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 8'h00;
            slverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            slverr_reg <= slverr_next;
        end
    end

    // Sensor registers
    always_comb begin
        logic [1:0] ax;
        ax        = axis_of(idx);
        samp_next = sample_valid ?
            {sample_z, sample_y, sample_x} : samp_reg;
        lock_next = lock_reg;
        hold_next = hold_reg;
        if (rd && is_axis(idx) && !idx[0]) begin
            lock_next[ax]        = 1'b1;
            hold_next[ax*8 +: 8] = samp_reg[ax*16+8 +: 8];
        end else if (rd && is_axis(idx)) begin
            lock_next[ax] = 1'b0;
        end
        if (cmd_soft) begin
            lock_next = 3'b000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_reg <= 48'h000000000000;
            lock_reg <= 3'b000;
            hold_reg <= 24'h000000;
        end else begin
            samp_reg <= samp_next;
            lock_reg <= lock_next;
            hold_reg <= hold_next;
        end
    end

    // Status flags
    always_comb begin
        // New sample wins over a clearing read in the same cycle
        drdy_next = sample_valid ? 1'b1 :
            ((rd && is_axis(idx)) ? 1'b0 : drdy_reg);
        irq_next  = sample_valid ? 1'b1 :
            ((rd && idx == ars_pkg::IDX_IRQ) ? 1'b0 : irq_reg);
        // A fault in the clearing cycle still sets the bit
        fatal_next = fatal_fault || (fatal_reg && !cmd_soft);
        if (cmd_soft) begin
            drdy_next = sample_valid;
            irq_next  = sample_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drdy_reg  <= 1'b0;
            irq_reg   <= 1'b0;
            fatal_reg <= 1'b0;
        end else begin
            drdy_reg  <= drdy_next;
            irq_reg   <= irq_next;
            fatal_reg <= fatal_next;
        end
    end

    // Time base and temperature sampling
    always_comb begin
        logic tick;
        tick      = (tick_reg == TICK_LAST);
        tick_next = tick ? 10'h000 : tick_reg + 10'h001;
        time_next = tick ? time_reg + 24'h000001 : time_reg;
        tcnt_next = (tcnt_reg == TEMP_LAST) ? 25'h0000000 :
            tcnt_reg + 25'h0000001;
        temp_next = (tcnt_reg == TEMP_LAST) ? temp_value : temp_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_reg <= 24'h000000;
            tick_reg <= 10'h000;
            temp_reg <= 11'h000;
            tcnt_reg <= 25'h0000000;
        end else begin
            time_reg <= time_next;
            tick_reg <= tick_next;
            temp_reg <= temp_next;
            tcnt_reg <= tcnt_next;
        end
    end

    // Buffer pointers
    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        nfrm_next = nfrm_reg;
        bidx_next = bidx_reg;
        if (port_rd) begin
            bidx_next = pop_frame ? 3'h0 : bidx_reg + 3'h1;
        end else if (rd) begin
            bidx_next = 3'h0;
        end
        if (pop_frame) begin
            rptr_next = next_ptr(rptr_reg);
            nfrm_next = nfrm_reg - 8'h01;
        end
        if (sample_valid) begin
            wptr_next = next_ptr(wptr_reg);
            if (full && !pop_frame) begin
                // Oldest frame dropped, partial read restarts
                rptr_next = next_ptr(rptr_reg);
                bidx_next = 3'h0;
            end else begin
                nfrm_next = nfrm_next + 8'h01;
            end
        end
        // Draining the last frame in a cycle with no new sample resets the buffer
        if (pop_frame && nfrm_reg == 8'h01 && !sample_valid) begin
            wptr_next = 8'h00;
            rptr_next = 8'h00;
        end
        if (cmd_flush || cmd_soft) begin
            wptr_next = 8'h00;
            rptr_next = 8'h00;
            nfrm_next = 8'h00;
            bidx_next = 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_reg <= 8'h00;
            rptr_reg <= 8'h00;
            nfrm_reg <= 8'h00;
            bidx_reg <= 3'h0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            nfrm_reg <= nfrm_next;
            bidx_reg <= bidx_next;
        end
    end
endmodule

// file: ars_output_regs_assertions.sv
// Purpose: Port-level checks of the output register bank
// Assumes: Master holds address and data until pready
// Notes:   Attached by bind below
`timescale 1ns/1ps
module ars_output_regs_assertions #(
    parameter int unsigned TEMP_CYCLES = ars_pkg::TEMP_CYCLES
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fatal_fault,
    input wire logic        config_invalid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic fatal_reg;
    logic fatal_next;
    logic rd_done;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    assign rd_done = psel && penable && pready && !pwrite;
    // Mirror of the sticky fatal flag, dropped by the soft reset command
    always_comb begin
        fatal_next = fatal_reg;
        if (fatal_fault)
            fatal_next = 1'b1;
        else if (psel && penable && !pready && pwrite &&
                 paddr == {ars_pkg::IDX_CMD, 2'b00} &&
                 pwdata[7:0] == ars_pkg::CMD_SOFT_RST)
            fatal_next = 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fatal_reg <= 1'b0;
        else
            fatal_reg <= fatal_next;
    end
    answer_wait_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    identity_code_a: assert property (rd_done && paddr == 10'h0 |->
        prdata[7:0] == ars_pkg::IDENTITY_CODE)
        else $error("identity code wrong");
    fault_code_a: assert property (rd_done && paddr == 10'h8 |->
        prdata[4:2] == ($past(config_invalid) ? 3'h1 : 3'h0)
        && prdata[7:5] == 3'h0 && !prdata[1])
        else $error("fault code wrong");
    fatal_sticky_a: assert property (rd_done && paddr == 10'h8 |->
        prdata[0] == $past(fatal_reg))
        else $error("fatal bit wrong");
    reserved_zero_a: assert property (rd_done &&
        (paddr == 10'hc || paddr == 10'h74) |-> prdata[6:0] == 7'h0)
        else $error("reserved status bits not zero");
    unaligned_err_a: assert property (rd_done && paddr[1:0] != 2'h0 |->
        pslverr)
        else $error("unaligned access not refused");
endmodule
bind ars_output_regs ars_output_regs_assertions #(
    .TEMP_CYCLES(TEMP_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fatal_fault(fatal_fault), .config_invalid(config_invalid));

// file: ars_host_model.sv
// Purpose: Host side APB master for the register bank
// Assumes: The bench watchdog bounds every wait for pready
// Notes:   Buffer bytes are fetched only through the data port
`timescale 1ns/1ps
module ars_host_model (
    // Clock
    input  wire logic        pclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h0;
        pwdata = 32'h0;
    end
    // Request held until the edge that sees pready
    task automatic xfer(input logic wr, input logic [9:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: accel_output_status_regs_tb.sv
// Purpose: Self-checking bench of the output register bank
// Assumes: Short temperature period, fixed tick of 781 cycles
// Notes:   Seeded random samples and temperature
`timescale 1ns/1ps
module accel_output_status_regs_tb;
    localparam int unsigned TC = 50;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        sample_valid, fatal_fault, config_invalid;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] sx, sy, sz;
    logic [10:0] temp_value;
    logic [47:0] f1, f2;
    logic [7:0]  t0;
    int          fails, tests_run, seed, i;

    ars_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ars_output_regs #(.TEMP_CYCLES(TC)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy),
        .sample_z(sz), .temp_value(temp_value), .fatal_fault(fatal_fault),
        .config_invalid(config_invalid));

    function automatic logic [9:0] ad(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction
    function automatic logic [31:0] fb(input logic [47:0] f, input int k);
        return {24'h0, f[8*k +: 8]};
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rdat, err);
        chk(rdat, exp);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, rdat, err);
    endtask
    task automatic push(output logic [47:0] f);
        f = 48'({$random(seed), $random(seed)});
        @(posedge pclk);
        sample_valid <= 1'b1;
        {sz, sy, sx} <= f;
        @(posedge pclk);
        sample_valid <= 1'b0;
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        print_verdict();
    end
    initial begin
        seed = 71479;
        {presetn, sample_valid, fatal_fault, config_invalid} = 4'h0;
        {sx, sy, sz, temp_value} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(ad(ars_pkg::IDX_IDENTITY), {24'h0, ars_pkg::IDENTITY_CODE});
        wr(ad(ars_pkg::IDX_IDENTITY), 8'hff);
        rd(ad(ars_pkg::IDX_IDENTITY), {24'h0, ars_pkg::IDENTITY_CODE});
        rd(ad(ars_pkg::IDX_CNT_LO), 32'h0);
        rd(ad(ars_pkg::IDX_CNT_HI), 32'h80);
        config_invalid <= 1'b1;
        rd(ad(ars_pkg::IDX_FAULT), 32'h4);
        config_invalid <= 1'b0;
        fatal_fault <= 1'b1;
        @(posedge pclk);
        fatal_fault <= 1'b0;
        rd(ad(ars_pkg::IDX_FAULT), 32'h1);
        rd(ad(ars_pkg::IDX_FAULT), 32'h1);
        wr(ad(ars_pkg::IDX_CMD), ars_pkg::CMD_SOFT_RST);
        rd(ad(ars_pkg::IDX_FAULT), 32'h0);
        // Axis bytes, flags and the high byte lock
        push(f1);
        rd(ad(ars_pkg::IDX_STATUS), 32'h80);
        rd(ad(ars_pkg::IDX_IRQ), 32'h80);
        rd(ad(ars_pkg::IDX_IRQ), 32'h0);
        rd(ad(ars_pkg::IDX_AXIS_LO), fb(f1, 0));
        rd(ad(ars_pkg::IDX_STATUS), 32'h0);
        push(f2);
        rd(ad(8'h13), fb(f1, 1));
        rd(ad(8'h14), fb(f2, 2));
        rd(ad(8'h15), fb(f2, 3));
        // Frame drain, partial frame repeat
        rd(ad(ars_pkg::IDX_CNT_LO), 32'd12);
        rd(ad(ars_pkg::IDX_CNT_HI), 32'h0);
        for (i = 0; i < 3; i++) rd(ad(ars_pkg::IDX_PORT), fb(f1, i));
        rd(ad(ars_pkg::IDX_CNT_LO), 32'd12);
        for (i = 0; i < 6; i++) rd(ad(ars_pkg::IDX_PORT), fb(f1, i));
        rd(ad(ars_pkg::IDX_CNT_LO), 32'd6);
        for (i = 0; i < 6; i++) rd(ad(ars_pkg::IDX_PORT), fb(f2, i));
        rd(ad(ars_pkg::IDX_CNT_HI), 32'h80);
        push(f1);
        wr(ad(ars_pkg::IDX_CMD), ars_pkg::CMD_FLUSH);
        rd(ad(ars_pkg::IDX_CNT_HI), 32'h80);
        rd(ad(ars_pkg::IDX_PORT), 32'h0);
        // Four cycles of transfer overhead, so the takes are ten ticks apart
        host.xfer(1'b0, ad(ars_pkg::IDX_TIME_0), 32'h0, rdat, err);
        t0 = rdat[7:0];
        repeat (10 * ars_pkg::TICK_CYCLES - 4) @(posedge pclk);
        rd(ad(ars_pkg::IDX_TIME_0), {24'h0, t0 + 8'd10});
        // Far fewer than 256 ticks have passed since reset
        rd(ad(ars_pkg::IDX_TIME_1), 32'h0);
        temp_value <= 11'($random(seed));
        repeat (TC + 2) @(posedge pclk);
        rd(ad(ars_pkg::IDX_TEMP_HI), {24'h0, temp_value[10:3]});
        rd(ad(ars_pkg::IDX_TEMP_LO), {24'h0, temp_value[2:0], 5'h0});
        host.xfer(1'b0, 10'h3fc, 32'h0, rdat, err);
        chk({31'h0, err}, 32'h1);
        host.xfer(1'b0, 10'h001, 32'h0, rdat, err);
        chk({31'h0, err}, 32'h1);
        print_verdict();
    end
endmodule
